// file: rtl/msq_consts.svh
`ifndef MSQ_CONSTS_SVH
`define MSQ_CONSTS_SVH
`define MSQ_CLK_HZ          20000000
`define MSQ_RX_SQ_MS        15
`define MSQ_TX_SQ_MS        400
`define MSQ_RX_SQ_CYC       ((`MSQ_RX_SQ_MS * (`MSQ_CLK_HZ / 1000)) - 8)
`define MSQ_TX_SQ_CYC       ((`MSQ_TX_SQ_MS * (`MSQ_CLK_HZ / 1000)) - 8)
`define MSQ_CNT_W           24
`define MSQ_ADDR_W          8
`define MSQ_DATA_W          8
`define MSQ_MEM_DEPTH       256
`define MSQ_RESET_DATA      8'h00
`define MSQ_BIT_ASSERTED    1'b1
`define MSQ_BIT_DEASSERTED  1'b0
`endif

// file: rtl/msq_pkg.sv
`default_nettype none
package msq_pkg;
   typedef enum logic [1:0] {
      MSQ_OP_READ,
      MSQ_OP_WRITE,
      MSQ_OP_TEST,
      MSQ_OP_NONE
   } msq_op_t;
   typedef struct packed {
      logic    valid;
      msq_op_t op;
      logic    has_addr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } msq_req_t;
   typedef struct packed {
      logic       valid;
      logic       ok;
      logic [7:0] rdata;
   } msq_rsp_t;
endpackage : msq_pkg
`default_nettype wire

// file: rtl/msq_squelch_chan.sv
`include "msq_consts.svh"
`default_nettype none
module msq_squelch_chan #(
   parameter logic [23:0] LIMIT = 24'h000001
) (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic enable,
   input  wire logic loss,
   output logic      squelched
);
   logic [`MSQ_CNT_W-1:0] count;
   logic [`MSQ_CNT_W-1:0] next_count;
   logic                  next_squelched;
   always_comb begin
      next_count     = '0;
      next_squelched = 1'b0;
      if (enable && loss) begin
         // bounded wait, then squelch; counter saturates
         if (count >= LIMIT) begin
            next_count     = count;
            next_squelched = 1'b1;
         end else begin
            next_count = count + 24'h000001;
         end
      end
      // clear or disable releases at once
   end
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         count     <= '0;
         squelched <= 1'b0;
      end else begin
         count     <= next_count;
         squelched <= next_squelched;
      end
   end
endmodule : msq_squelch_chan
`default_nettype wire

// file: rtl/msq_top.sv
`include "msq_consts.svh"
`default_nettype none
module msq_top #(
   parameter logic LP_PRESENT    = 1'b1,
   parameter logic LP_ACTIVE_LOW = 1'b0,
   parameter logic INT_ACTIVE_LOW = 1'b1
) (
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic              rx_auto_squelch_en,
   input  wire logic              tx_auto_squelch_en,
   input  wire logic              rx_input_loss,
   input  wire logic              tx_input_loss,
   input  wire logic              low_power_request_input,
   input  wire logic              int_request,
   input  wire msq_pkg::msq_req_t req,
   output var msq_pkg::msq_rsp_t  rsp,
   output logic                   rx_output_squelched,
   output logic                   tx_output_squelched,
   output logic                   low_power_requested,
   output logic                   int_pin
);
   // pins from outside: three flops, change taken when stages 2 and 3 agree
   // a glitch seen by only one stage never reaches the filtered level
   logic [2:0] pin_raw;
   logic [2:0] pin_level;
   logic       rx_loss, tx_loss, lp_level;
   assign pin_raw = {low_power_request_input, tx_input_loss, rx_input_loss};
   generate
      for (genvar i = 0; i < 3; i++) begin : g_sync
         logic [2:0] stage;
         logic [2:0] next_stage;
         logic       level;
         logic       next_level;
         always_comb begin
            next_stage = {stage[1:0], pin_raw[i]};
            next_level = (stage[2] == stage[1]) ? stage[2] : level;
         end
         always_ff @(posedge clock) begin
            if (!rst_n) begin
               stage <= 3'h0;
               level <= 1'b0;
            end else begin
               stage <= next_stage;
               level <= next_level;
            end
         end
         assign pin_level[i] = level;
      end
   endgenerate
   assign rx_loss  = pin_level[0];
   assign tx_loss  = pin_level[1];
   assign lp_level = pin_level[2];

   // synchroniser latency is taken out of the count limit
   logic rx_sq, tx_sq;
   msq_squelch_chan #(.LIMIT(24'(`MSQ_RX_SQ_CYC))) u_rx (
      .clock     (clock),
      .rst_n     (rst_n),
      .enable    (rx_auto_squelch_en),
      .loss      (rx_loss),
      .squelched (rx_sq)
   );
   msq_squelch_chan #(.LIMIT(24'(`MSQ_TX_SQ_CYC))) u_tx (
      .clock     (clock),
      .rst_n     (rst_n),
      .enable    (tx_auto_squelch_en),
      .loss      (tx_loss),
      .squelched (tx_sq)
   );

   // pin voltage to symbolic bit and back
   function automatic logic pin_to_bit(input logic volt, input logic act_low);
      pin_to_bit = act_low ? ~volt : volt;
   endfunction : pin_to_bit

   logic next_lp_req, next_int_pin;
   always_comb begin
      next_lp_req  = LP_PRESENT ? pin_to_bit(lp_level, LP_ACTIVE_LOW) : `MSQ_BIT_ASSERTED;
      next_int_pin = pin_to_bit(int_request, INT_ACTIVE_LOW);
   end
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rx_output_squelched <= 1'b0;
         tx_output_squelched <= 1'b0;
         low_power_requested <= `MSQ_BIT_ASSERTED;
         int_pin             <= INT_ACTIVE_LOW;
      end else begin
         rx_output_squelched <= rx_sq;
         tx_output_squelched <= tx_sq;
         low_power_requested <= next_lp_req;
         int_pin             <= next_int_pin;
      end
   end

   // management target: responds only to host requests
   logic [`MSQ_DATA_W-1:0] mem [`MSQ_MEM_DEPTH];
   logic [`MSQ_ADDR_W-1:0] cur_addr, next_cur_addr, acc_addr;
   msq_pkg::msq_rsp_t      next_rsp;
   logic                   do_write;
   always_comb begin
      acc_addr      = req.has_addr ? req.addr : cur_addr;
      next_cur_addr = cur_addr;
      next_rsp      = '0;
      do_write      = 1'b0;
      if (req.valid) begin
         unique case (req.op)
            msq_pkg::MSQ_OP_READ: begin
               next_rsp.valid = 1'b1;
               next_rsp.ok    = 1'b1;
               next_rsp.rdata = mem[acc_addr];
               next_cur_addr  = acc_addr + 8'h01;
            end
            msq_pkg::MSQ_OP_WRITE: begin
               next_rsp.valid = 1'b1;
               next_rsp.ok    = 1'b1;
               do_write       = 1'b1;
               next_cur_addr  = acc_addr + 8'h01;
            end
            msq_pkg::MSQ_OP_TEST: begin
               next_rsp.valid = 1'b1;
               next_rsp.ok    = 1'b1;
            end
            default: begin
               next_rsp.valid = 1'b1;
               next_rsp.ok    = 1'b0;
            end
         endcase
      end
   end
   always_ff @(posedge clock) begin
      if (do_write) begin
         mem[acc_addr] <= req.wdata;
      end
   end
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cur_addr <= '0;
         rsp      <= '0;
      end else begin
         cur_addr <= next_cur_addr;
         rsp      <= next_rsp;
      end
   end
endmodule : msq_top
`default_nettype wire

// file: verif/msq_host.sv
`default_nettype none
module msq_host (
   input  wire logic              clock,
   output var msq_pkg::msq_req_t  req,
   input  wire msq_pkg::msq_rsp_t rsp
);
   timeunit 1ns;
   timeprecision 1ns;
   initial req = '0;
   task automatic xfer(input msq_pkg::msq_op_t op, input logic ha, input logic [7:0] a, d,
                       output msq_pkg::msq_rsp_t r);
      @(posedge clock);
      req <= {1'b1, op, ha, a, d};
      @(posedge clock);
      req.valid <= 1'b0;
      // released addr and wdata flip so stale values never look valid
      req.addr <= ~a;
      req.wdata <= ~d;
      #1;
      r = rsp;
   endtask : xfer
endmodule : msq_host
`default_nettype wire

// file: verif/msq_top_sva.sv
`default_nettype none
module msq_chk (
   input wire logic              clock,
   input wire logic              rst_n,
   input wire logic              rx_auto_squelch_en,
   input wire logic              tx_auto_squelch_en,
   input wire logic              rx_input_loss,
   input wire logic              tx_input_loss,
   input wire logic              low_power_request_input,
   input wire logic              int_request,
   input wire msq_pkg::msq_req_t req,
   input wire msq_pkg::msq_rsp_t rsp,
   input wire logic              rx_output_squelched,
   input wire logic              tx_output_squelched,
   input wire logic              low_power_requested,
   input wire logic              int_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // too long for a delay range, so count
   logic [23:0] rx_cnt, next_rx_cnt, tx_cnt, next_tx_cnt;
   always_comb begin
      next_rx_cnt = (rst_n && rx_input_loss && rx_auto_squelch_en) ? rx_cnt + 24'h000001 : 24'h000000;
      next_tx_cnt = (rst_n && tx_input_loss && tx_auto_squelch_en) ? tx_cnt + 24'h000001 : 24'h000000;
   end
   always_ff @(posedge clock) begin
      rx_cnt <= next_rx_cnt;
      tx_cnt <= next_tx_cnt;
   end
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   rx_late_a: assert property (rx_cnt == 24'h0493E0 |-> rx_output_squelched)
      else $error("rx squelch late");
   tx_late_a: assert property (tx_cnt == 24'h7A1200 |-> tx_output_squelched)
      else $error("tx squelch late");
   rx_off_a: assert property (!rx_auto_squelch_en [*8] |-> !rx_output_squelched)
      else $error("rx squelch while off");
   rx_clear_a: assert property (!rx_input_loss [*8] ##1 !rx_input_loss [*8] |-> !rx_output_squelched)
      else $error("rx squelch stuck");
   int_level_a: assert property ($past(rst_n) |-> int_pin == !$past(int_request))
      else $error("int pin level");
   lp_follow_a: assert property (low_power_request_input [*8] |-> low_power_requested)
      else $error("low power bit");
   rsp_answer_a: assert property (req.valid |=> rsp.valid && rsp.ok == ($past(req.op) != msq_pkg::MSQ_OP_NONE))
      else $error("bad response");
   rsp_unasked_a: assert property (!req.valid |=> !rsp.valid)
      else $error("unasked response");
endmodule : msq_chk
bind msq_top msq_chk chk (.clock, .rst_n, .rx_auto_squelch_en, .tx_auto_squelch_en, .rx_input_loss,
   .tx_input_loss, .low_power_request_input, .int_request, .req, .rsp, .rx_output_squelched,
   .tx_output_squelched, .low_power_requested, .int_pin);
`default_nettype wire

// file: verif/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock, rst_n, en, loss, low_power_request_input, int_request;
   logic rx_output_squelched, tx_output_squelched, low_power_requested, int_pin;
   int n_errors, samples_checked;
   msq_pkg::msq_req_t req;
   msq_pkg::msq_rsp_t rsp, r;
   msq_top dut (.clock, .rst_n, .rx_auto_squelch_en(en), .tx_auto_squelch_en(en), .rx_input_loss(loss),
      .tx_input_loss(loss), .low_power_request_input, .int_request, .req, .rsp, .rx_output_squelched,
      .tx_output_squelched, .low_power_requested, .int_pin);
   msq_host host (.clock, .req, .rsp);
   task automatic chk(input string what, input logic [9:0] exp, got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic summarize();
      if (n_errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize
   task automatic t_access();
      host.xfer(msq_pkg::MSQ_OP_WRITE, 1'b1, 8'hFF, 8'hAA, r);
      chk("write", 10'h300, {r[9:8], 8'h00});
      host.xfer(msq_pkg::MSQ_OP_TEST, 1'b0, 8'h33, 8'h00, r);
      chk("test", 10'h300, {r[9:8], 8'h00});
      host.xfer(msq_pkg::MSQ_OP_WRITE, 1'b0, 8'h33, 8'h55, r);
      host.xfer(msq_pkg::MSQ_OP_READ, 1'b1, 8'hFF, 8'h00, r);
      chk("read", 10'h3AA, r);
      host.xfer(msq_pkg::MSQ_OP_READ, 1'b0, 8'h33, 8'h00, r);
      chk("read wrap", 10'h355, r);
      host.xfer(msq_pkg::MSQ_OP_NONE, 1'b0, 8'h00, 8'h00, r);
      chk("refused", 10'h200, {r[9:8], 8'h00});
   endtask : t_access
   task automatic t_pins();
      for (int v = 0; v < 2; v++) begin
         @(posedge clock);
         int_request <= v[0];
         low_power_request_input <= v[0];
         repeat (10) @(posedge clock);
         #1;
         chk("int pin", {9'h000, !v[0]}, {9'h000, int_pin});
         chk("low power", {9'h000, v[0]}, {9'h000, low_power_requested});
      end
   endtask : t_pins
   task automatic t_squelch();
      @(posedge clock);
      loss <= 1'b1;
      repeat (400) @(posedge clock);
      #1;
      chk("squelch off", 10'h000, {8'h00, rx_output_squelched, tx_output_squelched});
      @(posedge clock);
      en <= 1'b1;
      repeat (100) @(posedge clock);
      loss <= 1'b0;
      repeat (30) @(posedge clock);
      #1;
      chk("short loss", 10'h000, {8'h00, rx_output_squelched, tx_output_squelched});
   endtask : t_squelch
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   initial begin
      repeat (2000) @(posedge clock);
      n_errors++;
      summarize();
   end
   initial begin
      {rst_n, en, loss, low_power_request_input, int_request} = 5'h00;
      n_errors = 0;
      samples_checked = 0;
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      #1;
      chk("reset", 10'h003, {6'h00, rx_output_squelched, tx_output_squelched, low_power_requested, int_pin});
      t_access();
      t_pins();
      t_squelch();
      summarize();
   end
endmodule : tb
`default_nettype wire
